// File: rtl/torque_mode_limit_select.sv
// torque limit sources, speed/torque mode choice, torque reference ramp and apb registers
`timescale 1ns/1ns
`include "torque_defs.svh"

// Behaviour
// - analog full scale maps to a 300 % torque limit
// - 50 kHz pulse input maps to a 300 % torque limit
// - motoring source 6 takes the smaller analog, 7 the larger
// - motoring source 4 takes the serial host value, 5 the fieldbus value
// - braking source selector 0 to 7, digital 0 to 300 %, default 180 %
// - braking min and max sources pick smaller and larger analog values
// - negative torque limits become zero
// - mode is torque enable inverted while switch terminal is active
// - speed mode drives from the speed regulator within both limits
// - torque mode disables the speed regulator, uses the torque reference
// - torque reference channel 0 to 5, digital -300 to 300 %, default 0
// - analog torque reference keeps its sign, full scale 300 %
// - channels 4 and 5 use torque references written by the hosts
// - torque command ramps over 0 to 6000 s, default 6 s, torque mode only
// - overspeed in torque mode hands the command to the speed regulator
// - forward and reverse speed limit selectors 0 to 5, digital default zero
// - 50 kHz pulse input maps to a 100 % speed limit
// - digital 100 % speed limit equals the maximum output frequency
// - speed limit channels 4 and 5 use host written values
// - motoring digital limit 0 to 300 %, default 180 %
module torque_mode_limit_select #(
  parameter int unsigned GATE_CYCLES = `TQ_GATE_MS * `TQ_CLK_KHZ,
  parameter longint unsigned RAMP_UNIT_CYCLES = `TQ_RAMP_UNIT_MS * `TQ_CLK_KHZ
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic signed [15:0] i_analog_input_one,
  input wire logic signed [15:0] i_analog_input_two,
  input wire logic i_high_rate_pulse_input,
  input wire logic i_mode_switch_terminal,
  input wire torque_pkg::comm_values_t i_modbus,
  input wire torque_pkg::comm_values_t i_profinet,
  input wire logic signed [15:0] i_motor_speed,
  input wire logic signed [15:0] i_speed_loop_regulator_out,
  output logic o_speed_loop_regulator_en,
  output logic o_torque_mode,
  output logic signed [15:0] o_torque_cmd
);
  import torque_pkg::*;

  // software settings
  logic torque_mode_enable_q;
  logic [2:0] motoring_limit_source_sel_q;
  logic [2:0] braking_limit_source_sel_q;
  logic [2:0] torque_ref_channel_sel_q;
  logic [2:0] forward_speed_limit_sel_q;
  logic [2:0] reverse_speed_limit_sel_q;
  logic signed [15:0] motoring_limit_digital_q;
  logic signed [15:0] braking_limit_digital_q;
  logic signed [15:0] torque_ref_digital_q;
  logic [15:0] torque_ramp_time_q;
  logic signed [15:0] forward_speed_limit_digital_q;
  logic signed [15:0] reverse_speed_limit_digital_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  logic signed [15:0] wdata16;
  logic signed [15:0] lim_torque_in;
  logic signed [15:0] lim_ref_in;
  logic signed [15:0] lim_speed_in;
  logic [15:0] lim_ramp_in;

  // pin synchronisers and pulse measurement
  logic term_s1_q, term_s2_q;
  logic pulse_s1_q, pulse_s2_q, pulse_s3_q;
  logic [31:0] gate_cnt_q;
  logic [9:0] edge_cnt_q;
  logic [9:0] pulse_count_q;
  logic pulse_rise;

  // scaled sources
  logic signed [15:0] ai_torque [2];
  logic signed [15:0] ai_speed [2];
  logic signed [15:0] pulse_torque;
  logic signed [15:0] pulse_speed;
  logic signed [15:0] mot_lim;
  logic signed [15:0] brk_lim;
  logic signed [15:0] torque_ref_sel;
  logic signed [15:0] fwd_lim;
  logic signed [15:0] rev_lim;

  // control path
  ctrl_state_t state_q;
  ctrl_state_t state_d;
  logic torque_mode;
  logic overspeed;
  logic signed [15:0] ramp_q;
  logic [47:0] ramp_acc_q;
  logic [47:0] ramp_span;
  logic signed [15:0] raw_cmd;
  logic signed [15:0] lim_use;
  logic signed [15:0] cmd_d;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // apb decode: zero wait states, unmapped offsets answer with pslverr
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign wdata16 = i_pwdata[15:0];
  assign addr_hit = (i_paddr == `TQ_OFS_CTRL) || (i_paddr == `TQ_OFS_MOT_DIG) ||
                    (i_paddr == `TQ_OFS_BRK_DIG) || (i_paddr == `TQ_OFS_TREF_DIG) ||
                    (i_paddr == `TQ_OFS_RAMP) || (i_paddr == `TQ_OFS_FWD_DIG) ||
                    (i_paddr == `TQ_OFS_REV_DIG) || (i_paddr == `TQ_OFS_STATUS) ||
                    (i_paddr == `TQ_OFS_CMD) || (i_paddr == `TQ_OFS_LIMITS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_hit;
  assign o_prdata = prdata_q;

  // write data held inside the documented ranges
  assign lim_torque_in = (wdata16 < 16'sd0) ? 16'sd0 :
                         (wdata16 > `TQ_TORQUE_FULL) ? `TQ_TORQUE_FULL : wdata16;
  assign lim_ref_in = (wdata16 < -`TQ_TORQUE_FULL) ? -`TQ_TORQUE_FULL :
                      (wdata16 > `TQ_TORQUE_FULL) ? `TQ_TORQUE_FULL : wdata16;
  assign lim_speed_in = (wdata16 < 16'sd0) ? 16'sd0 :
                        (wdata16 > `TQ_SPEED_FULL) ? `TQ_SPEED_FULL : wdata16;
  assign lim_ramp_in = (i_pwdata[15:0] > `TQ_RAMP_MAX) ? `TQ_RAMP_MAX : i_pwdata[15:0];

  // setting registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      torque_mode_enable_q <= 1'b0;
      motoring_limit_source_sel_q <= 3'h0;
      braking_limit_source_sel_q <= 3'h0;
      torque_ref_channel_sel_q <= 3'h0;
      forward_speed_limit_sel_q <= 3'h0;
      reverse_speed_limit_sel_q <= 3'h0;
      motoring_limit_digital_q <= `TQ_RST_MOT_DIG;
      braking_limit_digital_q <= `TQ_RST_BRK_DIG;
      torque_ref_digital_q <= `TQ_RST_TREF_DIG;
      torque_ramp_time_q <= `TQ_RST_RAMP;
      forward_speed_limit_digital_q <= `TQ_RST_SPD_DIG;
      reverse_speed_limit_digital_q <= `TQ_RST_SPD_DIG;
    end else if (wr_en) begin
      case (i_paddr)
        `TQ_OFS_CTRL: begin
          torque_mode_enable_q <= i_pwdata[`TQ_CTRL_TMODE];
          motoring_limit_source_sel_q <= i_pwdata[`TQ_CTRL_MOT_LSB +: 3];
          braking_limit_source_sel_q <= i_pwdata[`TQ_CTRL_BRK_LSB +: 3];
          torque_ref_channel_sel_q <= i_pwdata[`TQ_CTRL_TREF_LSB +: 3];
          forward_speed_limit_sel_q <= i_pwdata[`TQ_CTRL_FWD_LSB +: 3];
          reverse_speed_limit_sel_q <= i_pwdata[`TQ_CTRL_REV_LSB +: 3];
        end
        `TQ_OFS_MOT_DIG: motoring_limit_digital_q <= lim_torque_in;
        `TQ_OFS_BRK_DIG: braking_limit_digital_q <= lim_torque_in;
        `TQ_OFS_TREF_DIG: torque_ref_digital_q <= lim_ref_in;
        `TQ_OFS_RAMP: torque_ramp_time_q <= lim_ramp_in;
        `TQ_OFS_FWD_DIG: forward_speed_limit_digital_q <= lim_speed_in;
        `TQ_OFS_REV_DIG: reverse_speed_limit_digital_q <= lim_speed_in;
        default: ;
      endcase
    end
  end

  // read data captured in the setup phase, stable through the access phase
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      case (i_paddr)
        `TQ_OFS_CTRL: prdata_q <= {8'h0, 1'b0, reverse_speed_limit_sel_q,
                                   1'b0, forward_speed_limit_sel_q,
                                   1'b0, torque_ref_channel_sel_q,
                                   1'b0, braking_limit_source_sel_q,
                                   1'b0, motoring_limit_source_sel_q,
                                   3'h0, torque_mode_enable_q};
        `TQ_OFS_MOT_DIG: prdata_q <= {16'h0, motoring_limit_digital_q};
        `TQ_OFS_BRK_DIG: prdata_q <= {16'h0, braking_limit_digital_q};
        `TQ_OFS_TREF_DIG: prdata_q <= {{16{torque_ref_digital_q[15]}}, torque_ref_digital_q};
        `TQ_OFS_RAMP: prdata_q <= {16'h0, torque_ramp_time_q};
        `TQ_OFS_FWD_DIG: prdata_q <= {16'h0, forward_speed_limit_digital_q};
        `TQ_OFS_REV_DIG: prdata_q <= {16'h0, reverse_speed_limit_digital_q};
        `TQ_OFS_STATUS: prdata_q <= {22'h0, pulse_count_q[9:0] == 10'h0 ? 1'b0 : 1'b1,
                                     term_s2_q, 4'h0, state_q, 1'b0, torque_mode};
        `TQ_OFS_CMD: prdata_q <= {{16{o_torque_cmd[15]}}, o_torque_cmd};
        `TQ_OFS_LIMITS: prdata_q <= {brk_lim, mot_lim};
        default: prdata_q <= 32'h0;
      endcase
    end
  end

  // two-stage synchronisers; the pulse edge detector looks at stages two and three
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      term_s1_q <= 1'b0;
      term_s2_q <= 1'b0;
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
      pulse_s3_q <= 1'b0;
    end else begin
      term_s1_q <= i_mode_switch_terminal;
      term_s2_q <= term_s1_q;
      pulse_s1_q <= i_high_rate_pulse_input;
      pulse_s2_q <= pulse_s1_q;
      pulse_s3_q <= pulse_s2_q;
    end
  end

  // pulse frequency: rising edges counted over a fixed gate, saturating;
  // an edge in the wrap cycle opens the next count, so none is lost
  assign pulse_rise = pulse_s2_q & ~pulse_s3_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_cnt_q <= 32'h0;
      edge_cnt_q <= 10'h0;
      pulse_count_q <= 10'h0;
    end else if (gate_cnt_q == GATE_CYCLES - 1) begin
      gate_cnt_q <= 32'h0;
      edge_cnt_q <= {9'h0, pulse_rise};
      pulse_count_q <= edge_cnt_q;
    end else begin
      gate_cnt_q <= gate_cnt_q + 32'h1;
      if (pulse_rise && edge_cnt_q != `TQ_PULSE_CNT_MAX) begin
        edge_cnt_q <= edge_cnt_q + 10'h1;
      end
    end
  end

  // 50 kHz gives 500 edges: x6 is 300 % torque, x20 is 100 % speed
  assign pulse_torque = 16'(signed'({6'h0, pulse_count_q}) * `TQ_PULSE_TORQUE_MUL);
  assign pulse_speed = 16'(signed'({6'h0, pulse_count_q}) * `TQ_PULSE_SPEED_MUL);

  // analog scaling per input: signed full scale to 300 % torque and 100 % speed
  for (genvar g = 0; g < 2; g++) begin : g_ai
    logic signed [15:0] ai_raw;
    logic signed [31:0] ai_t_prod;
    logic signed [31:0] ai_s_prod;
    assign ai_raw = (g == 0) ? i_analog_input_one : i_analog_input_two;
    assign ai_t_prod = ai_raw * 32'(`TQ_TORQUE_FULL);
    assign ai_s_prod = ai_raw * 32'(`TQ_SPEED_FULL);
    assign ai_torque[g] = 16'(ai_t_prod >>> `TQ_AI_SHIFT);
    assign ai_speed[g] = 16'(ai_s_prod >>> `TQ_AI_SHIFT);
  end

  // torque limit source: codes 0..7, result never negative
  function automatic logic signed [15:0] pick_limit(input logic [2:0] sel,
      input logic signed [15:0] dig, input logic signed [15:0] a1,
      input logic signed [15:0] a2, input logic signed [15:0] pl,
      input logic signed [15:0] mb, input logic signed [15:0] pn);
    logic signed [15:0] v;
    v = dig;
    case (sel)
      3'd0: v = dig;
      3'd1: v = a1;
      3'd2: v = a2;
      3'd3: v = pl;
      3'd4: v = mb;
      3'd5: v = pn;
      3'd6: v = (a1 < a2) ? a1 : a2;
      3'd7: v = (a1 > a2) ? a1 : a2;
      default: v = dig;
    endcase
    return (v < 16'sd0) ? 16'sd0 : v;
  endfunction

  // speed limit and torque reference channels: codes 0..5
  function automatic logic signed [15:0] pick_channel(input logic [2:0] sel,
      input logic signed [15:0] dig, input logic signed [15:0] a1,
      input logic signed [15:0] a2, input logic signed [15:0] pl,
      input logic signed [15:0] mb, input logic signed [15:0] pn);
    logic signed [15:0] v;
    v = 16'sd0;
    case (sel)
      3'd0: v = dig;
      3'd1: v = a1;
      3'd2: v = a2;
      3'd3: v = pl;
      3'd4: v = mb;
      3'd5: v = pn;
      default: v = 16'sd0;
    endcase
    return v;
  endfunction

  // selected limits and reference
  assign mot_lim = pick_limit(motoring_limit_source_sel_q, motoring_limit_digital_q,
                              ai_torque[0], ai_torque[1], pulse_torque,
                              i_modbus.motoring_limit, i_profinet.motoring_limit);
  assign brk_lim = pick_limit(braking_limit_source_sel_q, braking_limit_digital_q,
                              ai_torque[0], ai_torque[1], pulse_torque,
                              i_modbus.braking_limit, i_profinet.braking_limit);
  assign torque_ref_sel = pick_channel(torque_ref_channel_sel_q, torque_ref_digital_q,
                                       ai_torque[0], ai_torque[1], pulse_torque,
                                       i_modbus.torque_ref, i_profinet.torque_ref);
  assign fwd_lim = pick_channel(forward_speed_limit_sel_q, forward_speed_limit_digital_q,
                                ai_speed[0], ai_speed[1], pulse_speed,
                                i_modbus.forward_speed_limit,
                                i_profinet.forward_speed_limit);
  assign rev_lim = pick_channel(reverse_speed_limit_sel_q, reverse_speed_limit_digital_q,
                                ai_speed[0], ai_speed[1], pulse_speed,
                                i_modbus.reverse_speed_limit,
                                i_profinet.reverse_speed_limit);

  // mode choice and overspeed detection
  assign torque_mode = torque_mode_enable_q ^ term_s2_q;
  assign overspeed = (i_motor_speed > fwd_lim) || (i_motor_speed < -rev_lim);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SPEED, ST_TORQUE, ST_SPEED_HOLD: begin
        if (!torque_mode) begin
          state_d = ST_SPEED;
        end else if (overspeed) begin
          state_d = ST_SPEED_HOLD;
        end else begin
          state_d = ST_TORQUE;
        end
      end
      default: state_d = ST_SPEED;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_SPEED;
    end else begin
      state_q <= state_d;
    end
  end

  // ramp: one 0.1 % step each time the accumulator passes the span, 300 % per ramp time
  assign ramp_span = 48'(torque_ramp_time_q * RAMP_UNIT_CYCLES);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ramp_q <= 16'sd0;
      ramp_acc_q <= 48'h0;
    end else if (state_q != ST_TORQUE) begin
      ramp_q <= o_torque_cmd; // starts from the present command
      ramp_acc_q <= 48'h0;
    end else if (torque_ramp_time_q == 16'h0) begin
      ramp_q <= torque_ref_sel;
      ramp_acc_q <= 48'h0;
    end else if (ramp_acc_q + 48'(`TQ_TORQUE_FULL) >= ramp_span) begin
      ramp_acc_q <= 48'h0;
      if (ramp_q < torque_ref_sel) begin
        ramp_q <= ramp_q + 16'sd1;
      end else if (ramp_q > torque_ref_sel) begin
        ramp_q <= ramp_q - 16'sd1;
      end
    end else begin
      ramp_acc_q <= ramp_acc_q + 48'(`TQ_TORQUE_FULL);
    end
  end

  // final command and clamp by motoring or braking limit
  assign raw_cmd = (state_q == ST_TORQUE) ? ramp_q : i_speed_loop_regulator_out;
  assign lim_use = (raw_cmd[15] == i_motor_speed[15]) ? mot_lim : brk_lim;
  assign cmd_d = (raw_cmd > lim_use) ? lim_use :
                 (raw_cmd < -lim_use) ? -lim_use : raw_cmd;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_torque_cmd <= 16'sd0;
    end else begin
      o_torque_cmd <= cmd_d;
    end
  end

  assign o_speed_loop_regulator_en = (state_q != ST_TORQUE);
  assign o_torque_mode = (state_q != ST_SPEED);

  // checks
  property p_speed_mode;
    !torque_mode |=> state_q == ST_SPEED;
  endproperty
  a_speed_mode: assert property (p_speed_mode) else $error("speed mode not taken");

  property p_torque_mode;
    (torque_mode && !overspeed) |=> state_q == ST_TORQUE;
  endproperty
  a_torque_mode: assert property (p_torque_mode) else $error("torque mode not taken");

  property p_overspeed;
    (torque_mode && overspeed) |=> state_q == ST_SPEED_HOLD && o_speed_loop_regulator_en;
  endproperty
  a_overspeed: assert property (p_overspeed) else $error("overspeed not handed over");

  property p_nonneg;
    mot_lim >= 16'sd0 && brk_lim >= 16'sd0;
  endproperty
  a_nonneg: assert property (p_nonneg) else $error("negative torque limit");

  property p_min_sel;
    (motoring_limit_source_sel_q == 3'd6 && ai_torque[0] >= 16'sd0 &&
     ai_torque[1] >= ai_torque[0]) |-> mot_lim == ai_torque[0];
  endproperty
  a_min_sel: assert property (p_min_sel) else $error("min source wrong");

  property p_max_sel;
    (braking_limit_source_sel_q == 3'd7 && ai_torque[0] >= ai_torque[1] &&
     ai_torque[1] >= 16'sd0) |-> brk_lim == ai_torque[0];
  endproperty
  a_max_sel: assert property (p_max_sel) else $error("max source wrong");

  property p_ramp_step;
    (state_q == ST_TORQUE && torque_ramp_time_q != 16'h0) |=>
      ramp_q == $past(ramp_q) || ramp_q == $past(ramp_q) + 16'sd1 ||
      ramp_q == $past(ramp_q) - 16'sd1;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step too large");

  property p_clamp;
    1'b1 |=> o_torque_cmd <= $past(lim_use) && o_torque_cmd >= -$past(lim_use);
  endproperty
  a_clamp: assert property (p_clamp) else $error("command beyond limit");

  property p_dig_range;
    motoring_limit_digital_q <= `TQ_TORQUE_FULL && braking_limit_digital_q <= `TQ_TORQUE_FULL;
  endproperty
  a_dig_range: assert property (p_dig_range) else $error("digital limit out of range");
endmodule // torque_mode_limit_select

// File: rtl/torque_defs.svh
// register offsets, field positions, reset values, scales and timing for the torque selector
`ifndef TORQUE_DEFS_SVH
`define TORQUE_DEFS_SVH
// apb byte offsets
`define TQ_OFS_CTRL 8'h00
`define TQ_OFS_MOT_DIG 8'h04
`define TQ_OFS_BRK_DIG 8'h08
`define TQ_OFS_TREF_DIG 8'h0c
`define TQ_OFS_RAMP 8'h10
`define TQ_OFS_FWD_DIG 8'h14
`define TQ_OFS_REV_DIG 8'h18
`define TQ_OFS_STATUS 8'h1c
`define TQ_OFS_CMD 8'h20
`define TQ_OFS_LIMITS 8'h24
// control word field positions
`define TQ_CTRL_TMODE 0
`define TQ_CTRL_MOT_LSB 4
`define TQ_CTRL_BRK_LSB 8
`define TQ_CTRL_TREF_LSB 12
`define TQ_CTRL_FWD_LSB 16
`define TQ_CTRL_REV_LSB 20
// torque in 0.1 % rated, speed in 0.01 % of max output frequency, ramp in 0.1 s
`define TQ_TORQUE_FULL 16'sd3000
`define TQ_SPEED_FULL 16'sd10000
`define TQ_RAMP_MAX 16'd60000
`define TQ_RST_MOT_DIG 16'sd1800
`define TQ_RST_BRK_DIG 16'sd1800
`define TQ_RST_TREF_DIG 16'sd0
`define TQ_RST_RAMP 16'd60
`define TQ_RST_SPD_DIG 16'sd0
// pulse full scale 50 kHz gives 500 edges per 10 ms gate
`define TQ_PULSE_FULL_HZ 50000
`define TQ_PULSE_TORQUE_MUL 16'sd6
`define TQ_PULSE_SPEED_MUL 16'sd20
`define TQ_PULSE_CNT_MAX 10'd1023
`define TQ_AI_SHIFT 15
`define TQ_CLK_KHZ 125000
`define TQ_GATE_MS 10
`define TQ_RAMP_UNIT_MS 100
`endif

// File: rtl/torque_pkg.sv
// types shared by the torque mode and limit selector
package torque_pkg;
  // values written by one communication host
  typedef struct packed {
    logic signed [15:0] torque_ref;
    logic signed [15:0] motoring_limit;
    logic signed [15:0] braking_limit;
    logic signed [15:0] forward_speed_limit;
    logic signed [15:0] reverse_speed_limit;
  } comm_values_t;
  // control state of the torque path
  typedef enum logic [1:0] {ST_SPEED, ST_TORQUE, ST_SPEED_HOLD} ctrl_state_t;
endpackage

// File: tb/host_model.sv
// serial and fieldbus host model that writes the torque path values
`timescale 1ns/1ns

module host_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  output torque_pkg::comm_values_t o_modbus,
  output torque_pkg::comm_values_t o_profinet
);
  import torque_pkg::*;
  // both hosts rewrite their values just after every edge once out of reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_modbus <= '0;
      o_profinet <= '0;
    end else begin
      o_modbus <= '{16'sd400, 16'sd1000, 16'sd900, 16'sd5000, 16'sd5000};
      o_profinet <= '{16'sd600, 16'sd2500, 16'sd2200, 16'sd6000, 16'sd6000};
    end
  end
endmodule // host_model

// File: tb/tb.sv
// self-checking testbench for the torque mode and limit selector
`timescale 1ns/1ns
`include "torque_defs.svh"

module tb;
  import torque_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, term = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, reg_en, tmode;
  logic signed [15:0] ai1 = 16'sd16384, ai2 = -16'sd8192, spd = 16'sd0, reg_out = 16'sd0, cmd;
  comm_values_t mb, pn;
  int fails = 0, num_checks = 0;
  logic pulse = 1'b0;
  logic [3:0] pdiv = 4'h0;
  // expected limits per source code; the pulse code sees 100 edges per gate, six each
  logic [15:0] em [8] = '{16'h0708, 16'h05dc, 16'h0, 16'h0258,
                          16'h03e8, 16'h09c4, 16'h0, 16'h05dc};
  logic [15:0] eb [8] = '{16'h0708, 16'h05dc, 16'h0, 16'h0258,
                          16'h0384, 16'h0898, 16'h0, 16'h05dc};

  // 125 MHz clock
  always #4 clk = ~clk;

  // pulse pin: one rising edge every ten clocks
  always @(posedge clk) begin
    pdiv <= (pdiv == 4'd9) ? 4'h0 : pdiv + 4'h1;
    pulse <= (pdiv < 4'd5);
  end

  host_model partner (.i_sys_clk(clk), .i_rst_b(rst_b), .o_modbus(mb), .o_profinet(pn));

  torque_mode_limit_select #(.GATE_CYCLES(1000), .RAMP_UNIT_CYCLES(100)) DUT (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_analog_input_one(ai1), .i_analog_input_two(ai2),
    .i_high_rate_pulse_input(pulse), .i_mode_switch_terminal(term), .i_modbus(mb),
    .i_profinet(pn), .i_motor_speed(spd), .i_speed_loop_regulator_out(reg_out),
    .o_speed_loop_regulator_en(reg_en), .o_torque_mode(tmode), .o_torque_cmd(cmd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access until pready, release
  task automatic apb(input int w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic t_regs;
    apb(0, `TQ_OFS_CTRL, 0);
    chk(rd, 32'h0);
    apb(0, `TQ_OFS_MOT_DIG, 0);
    chk(rd, 32'h708);
    apb(0, `TQ_OFS_BRK_DIG, 0);
    chk(rd, 32'h708);
    apb(0, `TQ_OFS_RAMP, 0);
    chk(rd, 32'h3c);
    apb(0, `TQ_OFS_FWD_DIG, 0);
    chk(rd, 32'h0);
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_limits;
    // two full pulse gates, so the pulse source holds a settled count
    repeat (2000) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      apb(1, `TQ_OFS_CTRL, (c << 4) | (c << 8));
      repeat (4) @(posedge clk);
      apb(0, `TQ_OFS_LIMITS, 0);
      chk(rd, {eb[c], em[c]});
    end
    // both analog inputs positive: motoring takes the smaller, braking the larger
    ai2 <= 16'sd8192;
    apb(1, `TQ_OFS_CTRL, 32'h760);
    repeat (4) @(posedge clk);
    apb(0, `TQ_OFS_LIMITS, 0);
    chk(rd, 32'h05dc_02ee);
    ai1 <= 16'sd4096;
    repeat (4) @(posedge clk);
    apb(0, `TQ_OFS_LIMITS, 0);
    chk(rd, 32'h02ee_0177);
    $display("test limits done");
  endtask

  task automatic t_mode;
    apb(1, `TQ_OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    chk({30'h0, tmode, reg_en}, 32'h2);
    term <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, tmode, reg_en}, 32'h1);
    term <= 1'b0;
    repeat (6) @(posedge clk);
    $display("test mode done");
  endtask

  task automatic t_ramp;
    apb(1, `TQ_OFS_TREF_DIG, 32'd500);
    repeat (100) @(posedge clk);
    chk({31'h0, cmd > 16'sd0 && cmd < 16'sd500}, 32'h1);
    repeat (1200) @(posedge clk);
    chk(32'(cmd), 32'd500);
    $display("test ramp done");
  endtask

  task automatic t_overspeed;
    apb(1, `TQ_OFS_RAMP, 0);
    apb(1, `TQ_OFS_FWD_DIG, 32'd100);
    spd <= 16'sd200;
    reg_out <= 16'sd300;
    repeat (6) @(posedge clk);
    chk(32'(cmd), 32'd300);
    apb(0, `TQ_OFS_STATUS, 0);
    chk({30'h0, rd[3:2]}, 32'h2);
    $display("test overspeed done");
  endtask

  task automatic t_speed;
    apb(1, `TQ_OFS_CTRL, 0);
    apb(1, `TQ_OFS_BRK_DIG, 32'd700);
    spd <= 16'sd100;
    reg_out <= 16'sd3000;
    repeat (6) @(posedge clk);
    chk(32'(cmd), 32'd1800);
    reg_out <= -16'sd3000;
    repeat (6) @(posedge clk);
    chk(32'(cmd), -32'sd700);
    $display("test speed done");
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_limits;
    t_mode;
    t_ramp;
    t_overspeed;
    t_speed;
    finish_test;
  end
endmodule // tb
